// ### core/ttp_pkg.sv
// package: register map, field positions and carriers for the triple timer unit
package ttp_pkg;
  // ==========================================================================
  // register indices (byte address = index)
  localparam logic [3:0] REG_TMR_A = 4'h0;
  localparam logic [3:0] REG_TMR_A_MODE = 4'h1;
  localparam logic [3:0] REG_POWER_CTRL = 4'h2;
  localparam logic [3:0] REG_IRQ_FLAG = 4'h3;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] REG_TMR_B = 4'h5;
  localparam logic [3:0] REG_TMR_B_CTRL_A = 4'h6;
  localparam logic [3:0] REG_TMR_B_CTRL_B = 4'h7;
  localparam logic [3:0] REG_PWM_A_DUTY = 4'h8;
  localparam logic [3:0] REG_BUZZER_A = 4'h9;
  localparam logic [3:0] REG_PRESC_B_VAL = 4'ha;
  localparam logic [3:0] REG_TMR_C = 4'hb;
  localparam logic [3:0] REG_TMR_C_CTRL_A = 4'hc;
  localparam logic [3:0] REG_TMR_C_CTRL_B = 4'hd;
  localparam logic [3:0] REG_PRESC_C_VAL = 4'he;
  localparam logic [3:0] REG_CASCADE = 4'hf;
  // ==========================================================================
  // field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_ONE_SHOT = 2;
  localparam int BIT_PRESC_OFF = 3;
  localparam int BIT_EDGE = 4;
  localparam int BIT_SOURCE = 5;
  localparam int BIT_PWM_POL = 6;
  localparam int BIT_OUT_EN = 7;
  localparam int BIT_LOW_CLK = 7;
  localparam int BIT_GIE = 7;
  localparam int BIT_BZ_SRC = 3;
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 3;
  localparam int FLAG_C = 5;
  // ==========================================================================
  // reset values and counter constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] IRQ_FLAG_MASK = 8'h29;
  // ==========================================================================
  // register bus and pin carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ttp_req_s;
  typedef struct packed {
    logic pwmPin;
    logic pwmOe;
    logic buzzPin;
    logic buzzOe;
    logic irq;
  } ttp_pins_s;
endpackage

// ### core/ttp_timer_unit.sv
// file: triple 8-bit timer unit with prescalers, pwm and buzzer
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// down-counting timer slice, shared by timers b and c
module ttp_down_timer (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic enable,
  input wire logic oneShot,
  input wire logic reloadSel,
  input wire logic load,
  input wire logic [7:0] loadVal,
  output logic [7:0] count,
  output logic [7:0] reloadVal,
  output logic underflow
);
  import ttp_pkg::*;
  logic done_r;

  // one-shot stops after its single pass until rewritten or re-enabled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= RST_BYTE;
      reloadVal <= RST_BYTE;
      done_r <= 1'b0;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (load) begin
        count <= loadVal;
        reloadVal <= loadVal;
        done_r <= 1'b0;
      end else if (!enable) begin
        // a finished one-shot rearms from its start value, not from zero
        if (done_r) begin
          count <= reloadVal; // R11
        end
        done_r <= 1'b0;
      end else if (tick && !done_r) begin
        if (count == CNT_ZERO) begin
          underflow <= 1'b1;
          if (oneShot) begin
            done_r <= 1'b1; // R10 R11
          end else begin
            count <= reloadSel ? reloadVal : CNT_MAX; // R12
          end
        end else begin
          count <= count - 8'h01;
        end
      end
    end
  end
endmodule

// ==========================================================================
// power-of-two prescaler: tick out every 2^(ratio+1) input ticks
module ttp_prescaler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tickIn,
  input wire logic clear,
  input wire logic [2:0] ratio,
  output logic [7:0] value,
  output logic tickOut
);
  import ttp_pkg::*;
  logic [7:0] mask;

  always_comb begin
    mask = 8'(({1'b0, 8'h01} << ({1'b0, ratio} + 4'h1)) - 9'h001);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      value <= RST_BYTE;
    end else if (clear) begin
      value <= RST_BYTE;
    end else if (tickIn) begin
      value <= (value == mask) ? RST_BYTE : value + 8'h01;
    end
  end

  assign tickOut = tickIn && (value == mask);
endmodule

// ==========================================================================
// Operation
// R1 - timer a counts up eight bits while enabled; writes load, reads show count
// R2 - timer a source: instruction clock, external pin or slow osc; edge bit picks edge
// R3 - firmware routes slow osc through prescaler a with ratio above four
// R4 - prescaler a serves timer a when assign bit zero; writing zero clears it
// R5 - prescaler a divides by two up to 256 from a 3-bit field
// R6 - timer a overflow sets flag 0; irq with enable and global enable
// R7 - timer b counts down; writes load reload register and counter, reads live count
// R8 - timer b runs when enabled; source bit picks pin, edge bit picks edge
// R9 - prescaler b active when its low-active bit clear; divides 2..256; readable
// R10 - one-shot bit makes timer b count once down to underflow
// R11 - after one-shot pass timer b holds until rewritten or re-enabled
// R12 - free-running timer b reloads start value or restarts from 0xff
// R13 - timer b underflow sets flag 3; irq with enable and global enable
// R14 - pwm a enable drives pin as output; polarity bit selects active low
// R15 - pwm frame follows timer b start; duty 0 never active, 0xff 255 clocks
// R16 - firmware keeps pwm duty not above timer b start value
// R17 - buzzer a drives pin; source prescaler b or timer b; divide 2..256
// R18 - timer c counts down when enabled; writes load both; reads live count
// R19 - timer c source bit picks second pin; edge bit picks edge
// R20 - cascade option clocks timer c from timer b underflow
// R21 - prescaler c active when its low-active bit clear; divides 2..256; readable
// R22 - timer c one-shot or free-running with reload or 0xff restart
// R23 - timer c underflow sets flag 5; irq with enable and global enable
// R24 - global enable bit 7 of power control gates every timer irq
module ttp_timer_unit (
  input wire logic core_clk,
  input wire logic nrst,
  input wire ttp_pkg::ttp_req_s req,
  output logic [7:0] rdata,
  input wire logic instrTick,
  input wire logic extClockPinA,
  input wire logic extClockPinB,
  input wire logic slowOsc,
  output ttp_pkg::ttp_pins_s pins
);
  import ttp_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0] tmrA_r, modeA_r, powerCtrl_r, irqFlag_r, irqEnable_r;
  logic [7:0] ctrlBA_r, ctrlBB_r, duty_r, buzzCtrl_r, ctrlCA_r, ctrlCB_r, cascade_r;
  logic [7:0] rdata_r;
  logic [2:0] syncA_r, syncB_r, syncS_r;
  logic [7:0] cntB, cntC, rldB, rldC, pvB, pvC;
  logic ufB, ufC, tickA, tickB, tickC, ptA, ptB, ptC;
  logic pwmLevel_r, buzzLevel_r, irq_r;
  logic [7:0] buzzCnt_r;
  ttp_pins_s pins_r;

  function automatic logic edgeSel(input logic [2:0] s, input logic fall);
    edgeSel = fall ? (s[2] && !s[1]) : (!s[2] && s[1]);
  endfunction

  // ==========================================================================
  // pin synchronisers: stage 0 feeds stage 1 only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
      syncS_r <= 3'h0;
    end else begin
      syncA_r <= {syncA_r[1:0], extClockPinA};
      syncB_r <= {syncB_r[1:0], extClockPinB};
      syncS_r <= {syncS_r[1:0], slowOsc};
    end
  end

  // ==========================================================================
  // clock source selection
  logic srcA, srcB, srcC;
  always_comb begin
    if (!modeA_r[BIT_SOURCE]) begin
      srcA = instrTick; // R2
    end else if (modeA_r[BIT_LOW_CLK]) begin
      srcA = edgeSel(syncS_r, modeA_r[BIT_EDGE]); // R2
    end else begin
      srcA = edgeSel(syncA_r, modeA_r[BIT_EDGE]); // R2
    end
    srcB = ctrlBB_r[BIT_SOURCE] ? edgeSel(syncA_r, ctrlBB_r[BIT_EDGE]) : instrTick; // R8
    if (cascade_r[0]) begin
      srcC = ufB; // R20
    end else begin
      srcC = ctrlCB_r[BIT_SOURCE] ? edgeSel(syncB_r, ctrlCB_r[BIT_EDGE]) : instrTick; // R19
    end
  end

  // prescaler a clears when firmware writes zero to its assign bit
  logic clrA;
  assign clrA = req.wr && (req.addr == REG_TMR_A_MODE) && !req.wdata[BIT_PRESC_OFF]; // R4

  ttp_prescaler u_presA (.core_clk(core_clk), .nrst(nrst), .tickIn(srcA), .clear(clrA),
    .ratio(modeA_r[2:0]), .value(), .tickOut(ptA)); // R5
  // a disabled prescaler b or c is held clear so it restarts from zero when enabled
  ttp_prescaler u_presB (.core_clk(core_clk), .nrst(nrst), .tickIn(srcB),
    .clear(ctrlBB_r[BIT_PRESC_OFF]), .ratio(ctrlBB_r[2:0]), .value(pvB), .tickOut(ptB)); // R9
  ttp_prescaler u_presC (.core_clk(core_clk), .nrst(nrst), .tickIn(srcC),
    .clear(ctrlCB_r[BIT_PRESC_OFF]), .ratio(ctrlCB_r[2:0]), .value(pvC), .tickOut(ptC)); // R21

  assign tickA = modeA_r[BIT_PRESC_OFF] ? srcA : ptA; // R4
  assign tickB = ctrlBB_r[BIT_PRESC_OFF] ? srcB : ptB; // R9
  assign tickC = ctrlCB_r[BIT_PRESC_OFF] ? srcC : ptC; // R21

  // ==========================================================================
  // timers b and c
  ttp_down_timer u_tmrB (.core_clk(core_clk), .nrst(nrst), .tick(tickB),
    .enable(ctrlBA_r[BIT_ENABLE]), .oneShot(ctrlBA_r[BIT_ONE_SHOT]),
    .reloadSel(ctrlBA_r[BIT_RELOAD]), .load(req.wr && req.addr == REG_TMR_B),
    .loadVal(req.wdata), .count(cntB), .reloadVal(rldB), .underflow(ufB)); // R7 R10 R11 R12
  ttp_down_timer u_tmrC (.core_clk(core_clk), .nrst(nrst), .tick(tickC),
    .enable(ctrlCA_r[BIT_ENABLE]), .oneShot(ctrlCA_r[BIT_ONE_SHOT]),
    .reloadSel(ctrlCA_r[BIT_RELOAD]), .load(req.wr && req.addr == REG_TMR_C),
    .loadVal(req.wdata), .count(cntC), .reloadVal(rldC), .underflow(ufC)); // R18 R22

  // ==========================================================================
  // timer a
  logic ovfA;
  logic ovfEvt_r;
  assign ovfA = ovfEvt_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tmrA_r <= RST_BYTE;
      ovfEvt_r <= 1'b0;
    end else begin
      ovfEvt_r <= 1'b0;
      if (req.wr && req.addr == REG_TMR_A) begin
        tmrA_r <= req.wdata; // R1
      end else if (powerCtrl_r[BIT_ENABLE] && tickA) begin
        tmrA_r <= tmrA_r + 8'h01; // R1
        ovfEvt_r <= (tmrA_r == CNT_MAX);
      end
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      modeA_r <= RST_BYTE;
      powerCtrl_r <= RST_BYTE;
      irqEnable_r <= RST_BYTE;
      ctrlBA_r <= RST_BYTE;
      ctrlBB_r <= RST_BYTE;
      duty_r <= RST_BYTE;
      buzzCtrl_r <= RST_BYTE;
      ctrlCA_r <= RST_BYTE;
      ctrlCB_r <= RST_BYTE;
      cascade_r <= RST_BYTE;
    end else if (req.wr) begin
      case (req.addr)
        REG_TMR_A_MODE: modeA_r <= req.wdata;
        REG_POWER_CTRL: powerCtrl_r <= req.wdata;
        REG_IRQ_ENABLE: irqEnable_r <= req.wdata;
        REG_TMR_B_CTRL_A: ctrlBA_r <= req.wdata;
        REG_TMR_B_CTRL_B: ctrlBB_r <= req.wdata;
        REG_PWM_A_DUTY: duty_r <= req.wdata;
        REG_BUZZER_A: buzzCtrl_r <= req.wdata;
        REG_TMR_C_CTRL_A: ctrlCA_r <= req.wdata;
        REG_TMR_C_CTRL_B: ctrlCB_r <= req.wdata;
        REG_CASCADE: cascade_r <= req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // flags: a set in the clearing cycle wins
  logic [7:0] setMask;
  assign setMask = {2'b00, ufC, 1'b0, ufB, 2'b00, ovfA};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqFlag_r <= RST_BYTE;
    end else if (req.wr && req.addr == REG_IRQ_FLAG) begin
      irqFlag_r <= ((irqFlag_r & req.wdata) | setMask) & IRQ_FLAG_MASK; // R6 R13 R23
    end else begin
      irqFlag_r <= irqFlag_r | setMask; // R6 R13 R23
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= powerCtrl_r[BIT_GIE] && |(irqFlag_r & irqEnable_r & IRQ_FLAG_MASK); // R24
    end
  end

  // ==========================================================================
  // pwm a: active while count is below duty, frame set by the start value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwmLevel_r <= 1'b0;
    end else begin
      pwmLevel_r <= (cntB < duty_r) ^ ctrlBA_r[BIT_PWM_POL]; // R15 R14
    end
  end

  // ==========================================================================
  // buzzer a: toggles every 2^field source ticks, halving the rate once more
  logic buzzSrc;
  logic [7:0] buzzMask;
  assign buzzSrc = buzzCtrl_r[BIT_BZ_SRC] ? ufB : ptB; // R17
  assign buzzMask = 8'(({1'b0, 8'h01} << {1'b0, buzzCtrl_r[2:0]}) - 9'h001);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      buzzCnt_r <= RST_BYTE;
      buzzLevel_r <= 1'b0;
    end else if (buzzSrc) begin
      if (buzzCnt_r == buzzMask) begin
        buzzCnt_r <= RST_BYTE;
        buzzLevel_r <= !buzzLevel_r; // R17
      end else begin
        buzzCnt_r <= buzzCnt_r + 8'h01;
      end
    end
  end

  // ==========================================================================
  // pins, all registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pins_r <= '0;
    end else begin
      pins_r.pwmOe <= ctrlBA_r[BIT_OUT_EN]; // R14
      pins_r.pwmPin <= ctrlBA_r[BIT_OUT_EN] & pwmLevel_r;
      pins_r.buzzOe <= buzzCtrl_r[BIT_OUT_EN]; // R17
      pins_r.buzzPin <= buzzCtrl_r[BIT_OUT_EN] & buzzLevel_r;
      pins_r.irq <= irq_r;
    end
  end
  assign pins = pins_r;

  // ==========================================================================
  // read port: data in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= RST_BYTE;
    end else if (req.rd) begin
      case (req.addr)
        REG_TMR_A: rdata_r <= tmrA_r; // R1
        REG_TMR_A_MODE: rdata_r <= modeA_r;
        REG_POWER_CTRL: rdata_r <= powerCtrl_r;
        REG_IRQ_FLAG: rdata_r <= irqFlag_r;
        REG_IRQ_ENABLE: rdata_r <= irqEnable_r;
        REG_TMR_B: rdata_r <= cntB; // R7
        REG_TMR_B_CTRL_A: rdata_r <= ctrlBA_r;
        REG_TMR_B_CTRL_B: rdata_r <= ctrlBB_r;
        REG_PWM_A_DUTY: rdata_r <= duty_r;
        REG_BUZZER_A: rdata_r <= buzzCtrl_r;
        REG_PRESC_B_VAL: rdata_r <= pvB; // R9
        REG_TMR_C: rdata_r <= cntC; // R18
        REG_TMR_C_CTRL_A: rdata_r <= ctrlCA_r;
        REG_TMR_C_CTRL_B: rdata_r <= ctrlCB_r;
        REG_PRESC_C_VAL: rdata_r <= pvC; // R21
        REG_CASCADE: rdata_r <= cascade_r;
        default: rdata_r <= RST_BYTE;
      endcase
    end else begin
      rdata_r <= RST_BYTE;
    end
  end
  assign rdata = rdata_r;

  // ==========================================================================
  // checks
  a_flag_b_sets: assert property (@(posedge core_clk) disable iff (!nrst) // R13
    ufB |=> irqFlag_r[FLAG_B]) else $error("timer b underflow did not set flag");
  a_flag_c_sets: assert property (@(posedge core_clk) disable iff (!nrst) // R23
    ufC |=> irqFlag_r[FLAG_C]) else $error("timer c underflow did not set flag");
  a_flag_a_sets: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    ovfA |=> irqFlag_r[FLAG_A]) else $error("timer a overflow did not set flag");
  a_gie_gates_irq: assert property (@(posedge core_clk) disable iff (!nrst) // R24
    !powerCtrl_r[BIT_GIE] |=> !irq_r) else $error("irq raised without global enable");
  a_load_b_value: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    (req.wr && req.addr == REG_TMR_B) |=> (cntB == $past(req.wdata) && rldB == cntB))
    else $error("timer b load lost");
  a_load_c_value: assert property (@(posedge core_clk) disable iff (!nrst) // R18
    (req.wr && req.addr == REG_TMR_C) |=> (cntC == $past(req.wdata) && rldC == cntC))
    else $error("timer c load lost");
  a_oneshot_holds: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    (ufB && ctrlBA_r[BIT_ONE_SHOT] && ctrlBA_r[BIT_ENABLE] && !req.wr) |=> !ufB [*2])
    else $error("one-shot timer b kept running");
  a_read_timing: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    (req.rd && req.addr == REG_TMR_A && !$past(req.wr)) |=> rdata_r == $past(tmrA_r))
    else $error("timer a read wrong");
  a_pwm_oe: assert property (@(posedge core_clk) disable iff (!nrst) // R14
    ctrlBA_r[BIT_OUT_EN] |=> pins_r.pwmOe) else $error("pwm pin not driven");
endmodule

`default_nettype wire

// ### verification/tb_ttp_timer_unit.sv
// testbench: register-level checks of the triple timer unit
`timescale 1ns/1ps
`default_nettype none

module tb_ttp_timer_unit;
  import ttp_pkg::*;
  // ==========================================================================
  // stimulus and observation
  logic core_clk;
  logic nrst;
  ttp_req_s req;
  logic [7:0] rdata;
  logic instrTick;
  logic extClockPinA;
  logic extClockPinB;
  logic slowOsc;
  ttp_pins_s pins;
  int nMismatch;
  int checksDone;

  ttp_timer_unit ttp_timer_unit_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .req(req),
    .rdata(rdata),
    .instrTick(instrTick),
    .extClockPinA(extClockPinA),
    .extClockPinB(extClockPinB),
    .slowOsc(slowOsc),
    .pins(pins)
  );

  initial begin
    core_clk = 1'b0;
  end
  always #5 core_clk = ~core_clk;

  // ==========================================================================
  // bus and pin tasks
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // spaced one-cycle instruction ticks, effects settle before return
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      instrTick <= 1'b1;
      @(posedge core_clk);
      instrTick <= 1'b0;
      waitc(2);
    end
  endtask

  // level held long enough for the three-stage synchroniser
  task automatic pin(input int sel, input logic v);
    @(posedge core_clk);
    case (sel)
      0: extClockPinA <= v;
      1: extClockPinB <= v;
      default: slowOsc <= v;
    endcase
    waitc(6);
  endtask

  task automatic irqChk(input logic exp);
    waitc(4);
    chk({7'h00, pins.irq}, {7'h00, exp});
  endtask

  // ==========================================================================
  // shared down-timer scenario for timers b and c
  task automatic downTest(input bit c);
    logic [3:0] cnt;
    logic [3:0] ca;
    logic [3:0] cb;
    logic [3:0] pv;
    logic [7:0] fm;
    logic [7:0] v;
    cnt = c ? REG_TMR_C : REG_TMR_B;
    ca = c ? REG_TMR_C_CTRL_A : REG_TMR_B_CTRL_A;
    cb = c ? REG_TMR_C_CTRL_B : REG_TMR_B_CTRL_B;
    pv = c ? REG_PRESC_C_VAL : REG_PRESC_B_VAL;
    fm = c ? 8'h20 : 8'h08;
    wr(cb, 8'h08);
    wr(cnt, 8'h03);
    wr(ca, 8'h05);
    ticks(10);
    rchk(cnt, CNT_ZERO);
    rchk(REG_IRQ_FLAG, fm);
    wr(REG_IRQ_ENABLE, fm);
    irqChk(1'b0);
    wr(REG_POWER_CTRL, 8'h80);
    irqChk(1'b1);
    wr(REG_IRQ_FLAG, 8'h00);
    rchk(REG_IRQ_FLAG, 8'h00);
    irqChk(1'b0);
    wr(REG_POWER_CTRL, 8'h00);
    wr(REG_IRQ_ENABLE, 8'h00);
    // re-enable restarts from the stored start value
    wr(ca, 8'h00);
    wr(ca, 8'h05);
    ticks(1);
    rchk(cnt, 8'h02);
    wr(ca, 8'h00);
    ticks(2);
    rchk(cnt, 8'h02);
    // free running: reload versus restart from the top
    wr(cnt, 8'h03);
    wr(ca, 8'h03);
    ticks(5);
    rd(cnt, v);
    chk({7'h00, v <= 8'h03}, 8'h01);
    wr(ca, 8'h00);
    wr(cnt, 8'h03);
    wr(ca, 8'h01);
    ticks(5);
    rd(cnt, v);
    chk({7'h00, v >= 8'hf0}, 8'h01);
    // prescaler by 8, its running value readable
    wr(ca, 8'h00);
    wr(cnt, 8'h10);
    wr(cb, 8'h02);
    wr(ca, 8'h01);
    ticks(3);
    rchk(pv, 8'h03);
    rchk(cnt, 8'h10);
    ticks(5);
    rchk(cnt, 8'h0f);
    // external pin, rising then falling edge
    for (int e = 0; e < 2; e++) begin
      wr(cb, e ? 8'h38 : 8'h28);
      wr(cnt, 8'h10);
      pin(c, 1'b1);
      rchk(cnt, e ? 8'h10 : 8'h0f);
      pin(c, 1'b0);
      rchk(cnt, 8'h0f);
    end
    wr(ca, 8'h00);
    wr(REG_IRQ_FLAG, 8'h00);
  endtask

  // ==========================================================================
  // run control
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    waitc(40000);
    nMismatch++;
    completeRun();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    instrTick = 1'b0;
    extClockPinA = 1'b0;
    extClockPinB = 1'b0;
    slowOsc = 1'b0;
    nMismatch = 0;
    checksDone = 0;
    waitc(12);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rchk(i[3:0], RST_BYTE);
    end
    // timer a: count from the written value, wrap and flag
    wr(REG_TMR_A_MODE, 8'h08);
    wr(REG_TMR_A, 8'hfe);
    wr(REG_POWER_CTRL, 8'h01);
    ticks(3);
    rchk(REG_TMR_A, 8'h01);
    rchk(REG_IRQ_FLAG, 8'h01);
    wr(REG_POWER_CTRL, 8'h00);
    ticks(2);
    rchk(REG_TMR_A, 8'h01);
    wr(REG_IRQ_ENABLE, 8'h01);
    irqChk(1'b0);
    wr(REG_POWER_CTRL, 8'h80);
    irqChk(1'b1);
    wr(REG_IRQ_FLAG, 8'h00);
    irqChk(1'b0);
    wr(REG_IRQ_ENABLE, 8'h00);
    // prescaler a: divide by 4, clear on write of assign bit, divide by 256
    wr(REG_TMR_A_MODE, 8'h01);
    wr(REG_TMR_A, 8'h00);
    wr(REG_POWER_CTRL, 8'h01);
    ticks(8);
    rchk(REG_TMR_A, 8'h02);
    ticks(3);
    wr(REG_TMR_A_MODE, 8'h01);
    ticks(3);
    rchk(REG_TMR_A, 8'h02);
    ticks(1);
    rchk(REG_TMR_A, 8'h03);
    wr(REG_TMR_A_MODE, 8'h07);
    wr(REG_TMR_A, 8'h00);
    ticks(255);
    rchk(REG_TMR_A, 8'h00);
    ticks(1);
    rchk(REG_TMR_A, 8'h01);
    // timer a from pin a, each edge polarity
    for (int e = 0; e < 2; e++) begin
      wr(REG_TMR_A_MODE, e ? 8'h38 : 8'h28);
      wr(REG_TMR_A, 8'h00);
      pin(0, 1'b1);
      rchk(REG_TMR_A, e ? 8'h00 : 8'h01);
      pin(0, 1'b0);
      rchk(REG_TMR_A, 8'h01);
    end
    // slow oscillator through prescaler by 8; pin a must be ignored
    wr(REG_TMR_A_MODE, 8'ha2);
    wr(REG_TMR_A, 8'h00);
    pin(0, 1'b1);
    pin(0, 1'b0);
    repeat (8) begin
      pin(2, 1'b1);
      pin(2, 1'b0);
    end
    rchk(REG_TMR_A, 8'h01);
    wr(REG_POWER_CTRL, 8'h00);
    wr(REG_IRQ_FLAG, 8'h00);
    downTest(1'b0);
    downTest(1'b1);
    // pwm a: output enable, polarity, duty against live count
    wr(REG_PWM_A_DUTY, 8'h00);
    wr(REG_TMR_B_CTRL_A, 8'h80);
    waitc(4);
    chk({6'h00, pins.pwmOe, pins.pwmPin}, 8'h02);
    wr(REG_TMR_B_CTRL_A, 8'hc0);
    waitc(4);
    chk({6'h00, pins.pwmOe, pins.pwmPin}, 8'h03);
    wr(REG_TMR_B_CTRL_B, 8'h08);
    wr(REG_TMR_B, 8'h10);
    wr(REG_PWM_A_DUTY, 8'h10);
    wr(REG_TMR_B_CTRL_A, 8'h81);
    waitc(4);
    chk({6'h00, pins.pwmOe, pins.pwmPin}, 8'h02);
    ticks(1);
    waitc(2);
    chk({6'h00, pins.pwmOe, pins.pwmPin}, 8'h03);
    wr(REG_TMR_B_CTRL_A, 8'h00);
    waitc(4);
    chk({7'h00, pins.pwmOe}, 8'h00);
    // buzzer a output enable for both sources
    for (int s = 0; s < 2; s++) begin
      wr(REG_BUZZER_A, s ? 8'h88 : 8'h80);
      waitc(4);
      chk({7'h00, pins.buzzOe}, 8'h01);
      wr(REG_BUZZER_A, 8'h00);
      waitc(4);
      chk({7'h00, pins.buzzOe}, 8'h00);
    end
    // buzzer a from timer b underflow; field one halves the toggle rate
    wr(REG_TMR_B, 8'h00);
    wr(REG_TMR_B_CTRL_A, 8'h03);
    wr(REG_BUZZER_A, 8'h89);
    waitc(3);
    begin
      logic lvl;
      lvl = pins.buzzPin;
      ticks(1);
      waitc(2);
      chk({7'h00, pins.buzzPin}, {7'h00, lvl});
      ticks(1);
      waitc(2);
      chk({7'h00, pins.buzzPin}, {7'h00, !lvl});
    end
    // cascade: timer c steps only on timer b underflow
    wr(REG_CASCADE, 8'h01);
    wr(REG_TMR_B_CTRL_B, 8'h08);
    wr(REG_TMR_C_CTRL_B, 8'h08);
    wr(REG_TMR_B, 8'h01);
    wr(REG_TMR_C, 8'h10);
    wr(REG_TMR_C_CTRL_A, 8'h01);
    wr(REG_TMR_B_CTRL_A, 8'h03);
    ticks(8);
    rchk(REG_TMR_C, 8'h0c);
    completeRun();
  end
endmodule

`default_nettype wire
